// ===== hw/fbp_pkg.sv
// package: constants and carrier types for the flash block protection logic
package fbp_pkg;
  // ------------------------------------------------------------
  // address map and decode
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] ARRAY_TOP = 16'hffff;
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hff7e;
  localparam logic [1:0] START_HI_BITS = 2'h3;
  localparam logic [5:0] START_LO_BITS = 6'h00;
  localparam logic [7:0] PROT_ALL_ONES = 8'hff;
  localparam logic [7:0] PROT_ALL_ZERO = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'hff;
  localparam logic [9:0] PAGE_MASK_HI = 10'h3ff;

  // ------------------------------------------------------------
  // sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FBP_IDLE = 3'b000,
    FBP_SEL = 3'b001,
    FBP_CHECKED = 3'b010,
    FBP_LATCHED = 3'b011,
    FBP_HV = 3'b100
  } fbp_state_e;

  // control bits written by software
  typedef struct packed {
    logic hv;
    logic mass;
    logic erase;
    logic program_select;
  } fbp_ctrl_s;

  // signals driven into the array
  typedef struct packed {
    logic hv_on;
    logic pgm_on;
    logic erase_on;
    logic mass_on;
    logic standby;
  } fbp_array_s;
endpackage

// ===== hw/fbp_range_check.sv
// module: decodes the protect start address and compares against it
module fbp_range_check (
  input wire logic [7:0] prot_byte_i,
  input wire logic [15:0] addr_i,
  input wire logic test_voltage_i,
  output logic [15:0] start_addr_o,
  output logic guarded_o
);
  // bits [13:6] from the byte, top two forced high, low six zero
  assign start_addr_o = {fbp_pkg::START_HI_BITS, prot_byte_i,
                         fbp_pkg::START_LO_BITS};

  wire all_zero = (prot_byte_i == fbp_pkg::PROT_ALL_ZERO);
  wire all_ones = (prot_byte_i == fbp_pkg::PROT_ALL_ONES);
  // start addr reaches up to the top, so >= means inside the range
  wire in_range = (addr_i >= start_addr_o) &&
                  (addr_i <= fbp_pkg::ARRAY_TOP);

  // zero byte guards everything, even below the c000 window
  assign guarded_o = !test_voltage_i && !all_ones &&
                     (all_zero || in_range);
endmodule

// ===== hw/fbp_block_protect.sv
// module: flash block protection and program/erase sequencing guard
// ------------------------------------------------------------
// ------------------------------------------------------------
module fbp_block_protect (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CTRL_WR_I,
  input wire fbp_pkg::fbp_ctrl_s CTRL_DATA_I,
  input wire logic PROT_RD_I,
  input wire logic ARRAY_WR_I,
  input wire logic [15:0] ARRAY_ADDR_I,
  input wire logic [7:0] ARRAY_DATA_I,
  input wire logic TEST_VOLTAGE_LEVEL_I,
  input wire logic WAIT_ENTRY_I,
  input wire logic STOP_ENTRY_I,
  output fbp_pkg::fbp_ctrl_s CTRL_O,
  output logic [7:0] PROTECT_START_BYTE_O,
  output logic [15:0] LATCHED_ADDR_O,
  output logic GUARDED_O,
  output logic HV_REFUSED_O,
  output fbp_pkg::fbp_array_s ARRAY_O
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fbp_pkg::fbp_state_e state_reg, state_next;
  fbp_pkg::fbp_ctrl_s ctrl_reg, ctrl_next;
  fbp_pkg::fbp_array_s array_reg, array_next;
  logic [7:0] prot_reg, prot_next;
  logic [15:0] laddr_reg, laddr_next;
  logic guarded_reg, refused_reg, refused_next;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [15:0] start_addr;
  logic guarded;
  fbp_range_check u_range (
    .prot_byte_i(prot_reg),
    .addr_i(laddr_reg),
    .test_voltage_i(TEST_VOLTAGE_LEVEL_I),
    .start_addr_o(start_addr),
    .guarded_o(guarded)
  );

  wire busy = ctrl_reg.program_select || ctrl_reg.erase;
  wire low_power = WAIT_ENTRY_I || STOP_ENTRY_I;
  wire abort = low_power && (busy || ctrl_reg.hv);
  wire prot_open = (prot_reg == fbp_pkg::PROT_ALL_ONES) ||
                   TEST_VOLTAGE_LEVEL_I;
  // mass erase is whole-array, so any guarded page forbids it
  wire mass_ok = prot_open;
  // interlock: a write asking for both selects keeps the old pair
  wire both_req = CTRL_DATA_I.program_select && CTRL_DATA_I.erase;
  wire new_pgm = both_req ? ctrl_reg.program_select :
                 (CTRL_DATA_I.program_select && !ctrl_reg.erase);
  wire new_erase = both_req ? ctrl_reg.erase :
                   (CTRL_DATA_I.erase && !ctrl_reg.program_select);
  wire hv_req = CTRL_WR_I && CTRL_DATA_I.hv && !ctrl_reg.hv;
  wire seq_ok = (state_reg == fbp_pkg::FBP_LATCHED) && busy;
  wire mass_block = ctrl_reg.erase && ctrl_reg.mass && !mass_ok;
  wire hv_grant = hv_req && seq_ok && !guarded &&
                  !mass_block;
  wire prot_in_page = (laddr_reg[15:6] ==
                       fbp_pkg::PROT_BYTE_ADDR[15:6]);
  wire prog_write = (state_reg == fbp_pkg::FBP_HV) && ctrl_reg.program_select &&
                    ARRAY_WR_I && !guarded;
  wire prog_hits_prot = prog_write &&
                        (ARRAY_ADDR_I == fbp_pkg::PROT_BYTE_ADDR);
  wire erase_done = (state_reg == fbp_pkg::FBP_HV) && ctrl_reg.erase &&
                    CTRL_WR_I && !CTRL_DATA_I.erase;
  wire erase_hits_prot = erase_done && !guarded &&
                         (ctrl_reg.mass || prot_in_page);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    laddr_next = laddr_reg;
    prot_next = prot_reg;
    refused_next = 1'b0;
    if (CTRL_WR_I) begin
      ctrl_next.program_select = new_pgm;
      ctrl_next.erase = new_erase;
      ctrl_next.mass = CTRL_DATA_I.mass;
      ctrl_next.hv = CTRL_DATA_I.hv ? (ctrl_reg.hv || hv_grant) : 1'b0;
      refused_next = hv_req && !hv_grant;
    end
    unique case (state_reg)
      fbp_pkg::FBP_IDLE: begin
        if (busy) state_next = fbp_pkg::FBP_SEL;
      end
      fbp_pkg::FBP_SEL: begin
        if (PROT_RD_I) state_next = fbp_pkg::FBP_CHECKED;
      end
      fbp_pkg::FBP_CHECKED: begin
        if (ARRAY_WR_I) begin
          laddr_next = ARRAY_ADDR_I;
          state_next = fbp_pkg::FBP_LATCHED;
        end
      end
      fbp_pkg::FBP_LATCHED: begin
        if (hv_grant) state_next = fbp_pkg::FBP_HV;
      end
      fbp_pkg::FBP_HV: begin
        if (!ctrl_reg.hv) state_next = fbp_pkg::FBP_IDLE;
      end
      default: state_next = fbp_pkg::FBP_IDLE;
    endcase
    // the protect byte follows only real array program/erase cycles
    if (prog_hits_prot) prot_next = prot_reg & ARRAY_DATA_I;
    if (erase_hits_prot) prot_next = fbp_pkg::PROT_ALL_ONES;
    if (!busy && !ctrl_reg.hv && state_reg != fbp_pkg::FBP_HV)
      state_next = busy ? state_next : fbp_pkg::FBP_IDLE;
    if (abort) begin
      ctrl_next = '0;
      state_next = fbp_pkg::FBP_IDLE;
    end
  end

  // standby drops every array control line
  always_comb begin
    array_next.hv_on = ctrl_next.hv && !abort;
    array_next.pgm_on = ctrl_next.program_select && !abort;
    array_next.erase_on = ctrl_next.erase && !abort;
    array_next.mass_on = ctrl_next.mass && ctrl_next.erase && !abort;
    array_next.standby = abort ||
                         (array_reg.standby && !busy && !CTRL_WR_I);
    if (array_next.standby) begin
      array_next.hv_on = 1'b0;
      array_next.pgm_on = 1'b0;
      array_next.erase_on = 1'b0;
      array_next.mass_on = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= fbp_pkg::FBP_IDLE;
      ctrl_reg <= '0;
      array_reg <= '0;
      prot_reg <= fbp_pkg::PROT_RESET;
      laddr_reg <= '0;
      guarded_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      array_reg <= array_next;
      prot_reg <= prot_next;
      laddr_reg <= laddr_next;
      guarded_reg <= guarded;
      refused_reg <= refused_next;
    end
  end

  assign CTRL_O = ctrl_reg;
  assign PROTECT_START_BYTE_O = prot_reg;
  assign LATCHED_ADDR_O = laddr_reg;
  assign GUARDED_O = guarded_reg;
  assign HV_REFUSED_O = refused_reg;
  assign ARRAY_O = array_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_NO_HV_GUARDED: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) hv_req && guarded |=> !ctrl_reg.hv)
    else $error("high voltage set inside guarded range");
  AST_INTERLOCK: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) !(ctrl_reg.program_select && ctrl_reg.erase))
    else $error("program and erase selected together");
  AST_HV_NEEDS_SEL: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) $rose(ctrl_reg.hv) |->
      $past(state_reg) == fbp_pkg::FBP_LATCHED)
    else $error("high voltage without proper sequence");
  AST_MASS_LOCK: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) hv_req && mass_block |=> !ctrl_reg.hv)
    else $error("mass erase allowed while protected");
  AST_ABORT: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) abort |=> ctrl_reg == '0 &&
      array_reg.standby && state_reg == fbp_pkg::FBP_IDLE)
    else $error("low power entry did not abort");
  AST_STANDBY: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) array_reg.standby |->
      !array_reg.hv_on && !array_reg.pgm_on && !array_reg.erase_on)
    else $error("array line active in standby");
  AST_START_ADDR: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) start_addr[15:14] == 2'h3 &&
      start_addr[5:0] == 6'h00 && start_addr[13:6] == prot_reg)
    else $error("start address decode wrong");
  AST_ALL_ONES_OPEN: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) prot_reg == 8'hff |-> !guarded)
    else $error("all-ones byte guarded something");
  AST_ZERO_GUARD: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) prot_reg == 8'h00 &&
      !TEST_VOLTAGE_LEVEL_I |-> guarded)
    else $error("all-zero byte left array open");
  AST_PROT_WRITE: assert property (@(posedge SYS_CLK_I)
    disable iff (!RESET_N_I) !prog_write && !erase_done |=>
      $stable(prot_reg))
    else $error("protect byte changed outside a sequence");
  COV_GRANT: cover property (@(posedge SYS_CLK_I) hv_grant);
  COV_REFUSE: cover property (@(posedge SYS_CLK_I) hv_req && guarded);
  COV_ABORT: cover property (@(posedge SYS_CLK_I) abort);
  COV_BYPASS: cover property (@(posedge SYS_CLK_I)
    TEST_VOLTAGE_LEVEL_I && prot_reg == 8'h00 && hv_grant);
endmodule

// ===== testbench/tb_top.sv
// testbench: random and corner sequences for the block protection logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, awr = 0, tv = 0, wt = 0, sp = 0;
  fbp_pkg::fbp_ctrl_s cd = '0;
  logic [15:0] ad = '0;
  logic [7:0] dd = '0, mb = 8'hff, pb;
  fbp_pkg::fbp_ctrl_s ctrl;
  logic [15:0] la;
  logic g, refd;
  fbp_pkg::fbp_array_s arr;
  int n_mismatch = 0, compares = 0;
  always #10 clk = ~clk;
  fbp_block_protect uut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .CTRL_WR_I(wr), .CTRL_DATA_I(cd), .PROT_RD_I(rd), .ARRAY_WR_I(awr),
    .ARRAY_ADDR_I(ad), .ARRAY_DATA_I(dd), .TEST_VOLTAGE_LEVEL_I(tv),
    .WAIT_ENTRY_I(wt), .STOP_ENTRY_I(sp), .CTRL_O(ctrl),
    .PROTECT_START_BYTE_O(pb), .LATCHED_ADDR_O(la), .GUARDED_O(g),
    .HV_REFUSED_O(refd), .ARRAY_O(arr));
  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] start_of(logic [7:0] b);
    return {2'h3, b, 6'h00};
  endfunction
  function automatic logic guard_of(logic [7:0] b, logic [15:0] a);
    return !tv && b != 8'hff && a >= start_of(b);
  endfunction
  function automatic logic [15:0] rnd_addr();
    return 16'hc000 | 16'($urandom() & 32'h3fff);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    compares++;
    if (e !== s) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // bus steps: drive after a falling edge, release one cycle later
  // ----------------------------------------------------------------
  task automatic cw(logic [3:0] d);
    @(negedge clk);
    wr = 1;
    cd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic pr();
    @(negedge clk);
    rd = 1;
    @(negedge clk);
    rd = 0;
  endtask
  task automatic aw(logic [15:0] a, logic [7:0] d);
    @(negedge clk);
    awr = 1;
    ad = a;
    dd = d;
    @(negedge clk);
    awr = 0;
  endtask
  // full select, read, dummy write, enable, program, clear sequence
  // wait and stop stay low inside a sequence
  task automatic op(logic [3:0] sel, logic [15:0] a, logic [7:0] d);
    logic gx, ok;
    logic [4:0] ea;
    gx = guard_of(mb, a);
    ok = !gx && !(sel[2] && mb != 8'hff && !tv);
    ea = {ok, sel[0], sel[1], sel[1] && sel[2], 1'b0};
    cw(sel);
    pr();
    aw(a, 8'hff);
    @(negedge clk);
    chk("latched_addr", a, la);
    chk("guarded", 16'(gx), 16'(g));
    cw(sel | 4'h8);
    chk("hv_granted", 16'(ok), 16'(ctrl.hv));
    chk("hv_refused", 16'(!ok), 16'(refd));
    chk("array_lines", 16'(ea), 16'(arr));
    if (sel[0]) aw(a, d);
    cw(4'h8);
    cw(4'h0);
    if (ok && sel[0] && a == 16'hff7e) mb = mb & d;
    if (ok && sel[1] && (sel[2] || a[15:6] == 10'h3fd)) mb = 8'hff;
    chk("protect_byte", 16'(mb), 16'(pb));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] vals [6];
    int i;
    int j;
    void'($urandom(32'ha915));
    repeat (5) @(negedge clk);
    rst_n = 1;
    chk("reset_byte", 16'h00ff, 16'(pb));
    for (i = 0; i < 4; i++) op(4'h1, rnd_addr(), 8'($urandom()));
    op(4'h6, 16'hc000, 8'h00);
    $display("test open array done");
    aw(16'hff7e, 8'h00);
    chk("plain_write", 16'h00ff, 16'(pb));
    op(4'h1, 16'hff7e, 8'hfd);
    op(4'h1, 16'hff40, 8'h00);
    op(4'h1, 16'hff3f, 8'h00);
    op(4'h2, 16'hff7e, 8'h00);
    op(4'h6, 16'hc000, 8'h00);
    $display("test fd protection done");
    vals = '{8'h00, 8'hfd, 8'hfe, 8'hfc, 8'($urandom()), 8'($urandom())};
    for (i = 0; i < 6; i++) begin
      tv = 1;
      op(4'h1, rnd_addr(), 8'h00);
      op(4'h2, 16'hff40, 8'h00);
      op(4'h1, 16'hff7e, vals[i]);
      tv = 0;
      op(4'h1, start_of(mb), 8'h00);
      if (mb != 8'h00) op(4'h1, start_of(mb) - 16'h1, 8'h00);
      for (j = 0; j < 2; j++) op(4'h1, rnd_addr(), 8'h00);
    end
    $display("test decoded start addresses done");
    cw(4'h3);
    chk("both_selects", 16'h0, 16'(ctrl));
    cw(4'h1);
    cw(4'h3);
    chk("select_kept", 16'h1, 16'(ctrl));
    cw(4'h9);
    chk("hv_no_sequence", 16'h1, 16'(ctrl));
    cw(4'h0);
    cw(4'h8);
    chk("hv_no_select", 16'h0, 16'(ctrl));
    cw(4'h0);
    $display("test interlock done");
    tv = 1;
    for (i = 0; i < 2; i++) begin
      cw(4'h1);
      pr();
      aw(16'hc000, 8'hff);
      cw(4'h9);
      chk("hv_before_abort", 16'h1, 16'(ctrl.hv));
      wt = (i == 0);
      sp = (i == 1);
      @(negedge clk);
      wt = 0;
      sp = 0;
      chk("ctrl_abort", 16'h0, 16'(ctrl));
      chk("array_standby", 16'h01, 16'(arr));
      cw(4'h0);
    end
    tv = 0;
    $display("test abort done");
    end_of_test();
  end
  // hang guard at 10000 cycles, far beyond the roughly 790 cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule
